// *** pkg/nfc_pkg.sv ***
package nfc_pkg;
	// ==========================================================
	// Register map, byte addresses on the peripheral bus.
	localparam logic [31:0] NFC_CONFIG = 32'h4e00_0000;
	localparam logic [31:0] NFC_CONTROL = 32'h4e00_0004;
	localparam logic [31:0] NFC_CMD = 32'h4e00_0008;
	localparam logic [31:0] NFC_ADDR = 32'h4e00_000c;
	localparam logic [31:0] NFC_DATA = 32'h4e00_0010;
	localparam logic [31:0] NFC_MECCD0 = 32'h4e00_0014;
	localparam logic [31:0] NFC_MECCD1 = 32'h4e00_0018;
	localparam logic [31:0] NFC_STATUS = 32'h4e00_0020;
	localparam logic [31:0] NFC_MRES0 = 32'h4e00_002c;
	localparam logic [31:0] NFC_MRES1 = 32'h4e00_0030;
	localparam logic [31:0] NFC_SRES = 32'h4e00_0034;

	// ==========================================================
	// Field positions and reset values.
	localparam int CFG_WIDTH = 0;
	localparam int CTL_ENABLE = 0;
	localparam int CTL_CS_FORCE = 1;
	localparam int CTL_PARITY_CLEAR = 4;
	localparam int CTL_MAIN_FREEZE = 5;
	localparam int CTL_SPARE_FREEZE = 6;
	localparam int STATUS_RB = 0;
	localparam int STATUS_CE = 1;
	localparam int STATUS_BUSY = 8;
	localparam logic ENABLE_RST = 1'h0;
	localparam logic CS_FORCE_RST = 1'h1;
	localparam logic MAIN_FREEZE_RST = 1'h1;
	localparam logic SPARE_FREEZE_RST = 1'h1;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	// ==========================================================
	// Timing and buffering.
	localparam int CLK_MHZ = 100;
	localparam int STROBE_NS = 40;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 32;
	localparam int ENTRY_W = DATA_W + 2;

	typedef enum logic [1:0] {
		NFC_KIND_CMD = 2'h0,
		NFC_KIND_ADDR = 2'h1,
		NFC_KIND_DATA = 2'h2
	} nfc_kind_t;

	typedef enum logic [2:0] {
		NFC_S_IDLE = 3'h1,
		NFC_S_LOW = 3'h2,
		NFC_S_HIGH = 3'h4
	} nfc_seq_t;
endpackage : nfc_pkg

// *** pkg/nfc_stream_if.sv ***
`timescale 1ns/1ns
// ==========================================================
// Valid/ready word stream between the controller and its FIFO.
interface nfc_stream_if #(
	parameter int W = nfc_pkg::ENTRY_W
);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : nfc_stream_if

// *** verilog/nfc_fifo.sv ***
`timescale 1ns/1ns
// ==========================================================
// Flip-flop FIFO; ready and valid reflect the true fill level.
module nfc_fifo #(
	parameter int WIDTH = nfc_pkg::ENTRY_W,
	parameter int DEPTH = nfc_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_in,
	nfc_stream_if.sink push,
	nfc_stream_if.source pop
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] count_q;
	logic do_push;
	logic do_pop;

	assign do_push = push.valid && push.ready;
	assign do_pop = pop.valid && pop.ready;
	assign push.ready = count_q != FULL;
	assign pop.valid = count_q != '0;
	assign pop.data = mem_q[rd_q];

	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem_q[wr_q] <= push.data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
			end
			if (do_pop) begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + CW'(1);
			end else if (do_pop && !do_push) begin
				count_q <= count_q - CW'(1);
			end
		end
	end
endmodule : nfc_fifo

// *** verilog/nfc_ctrl.sv ***
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
// ==========================================================
// Flash controller: APB registers, command/address/data windows,
// flash bus sequencer and parity engine.
module nfc_ctrl #(
	parameter int STROBE_CYC = nfc_pkg::STROBE_CYC,
	parameter int FIFO_DEPTH = nfc_pkg::FIFO_DEPTH
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [31:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic BOOT_LOAD_IN,
	input wire logic WIDTH_STRAP_IN,
	input wire logic FLASH_RB_IN,
	input wire logic [15:0] FLASH_IO_IN,
	output logic [15:0] FLASH_IO_OUT,
	output logic FLASH_IO_OE_OUT,
	output logic FLASH_CHIP_ENABLE_N_OUT,
	output logic FLASH_CLE_OUT,
	output logic FLASH_ALE_OUT,
	output logic FLASH_WE_N_OUT,
	output logic FLASH_RE_N_OUT
);
	// ==========================================================
	// Decode helpers.
	function automatic logic is_mapped(input logic [31:0] a);
		return a == nfc_pkg::NFC_CONFIG || a == nfc_pkg::NFC_CONTROL ||
			a == nfc_pkg::NFC_CMD || a == nfc_pkg::NFC_ADDR ||
			a == nfc_pkg::NFC_DATA || a == nfc_pkg::NFC_MECCD0 ||
			a == nfc_pkg::NFC_MECCD1 || a == nfc_pkg::NFC_STATUS ||
			a == nfc_pkg::NFC_MRES0 || a == nfc_pkg::NFC_MRES1 ||
			a == nfc_pkg::NFC_SRES;
	endfunction : is_mapped

	function automatic logic is_fetch(input logic [31:0] a);
		return a == nfc_pkg::NFC_DATA || a == nfc_pkg::NFC_MECCD0 ||
			a == nfc_pkg::NFC_MECCD1;
	endfunction : is_fetch

	// The upper lane is forced to zero on a narrow bus so it never toggles.
	function automatic logic [15:0] lane_of(input logic [31:0] w, input logic wide);
		return wide ? w[15:0] : {8'h00, w[7:0]};
	endfunction : lane_of

	// ==========================================================
	// State.
	logic enable_q;
	logic cs_force_q;
	logic main_freeze_q;
	logic spare_freeze_q;
	logic width_q;
	logic strap_pend_q;
	logic [7:0] cmd_q;
	logic [7:0] addr_q;
	logic [31:0] meccd0_q;
	logic [31:0] meccd1_q;
	logic [31:0] main_res0_q;
	logic [31:0] main_res1_q;
	logic [31:0] spare_res_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic rd_req_q;
	logic rd_done_q;
	logic rb_s1_q;
	logic rb_s2_q;
	logic strap_s1_q;
	logic strap_s2_q;
	logic [15:0] io_s1_q;
	logic [15:0] io_s2_q;
	nfc_pkg::nfc_seq_t state_q;
	nfc_pkg::nfc_kind_t kind_q;
	logic [1:0] beat_q;
	logic reading_q;
	logic [31:0] word_q;
	logic [7:0] div_q;
	logic ce_n_q;
	logic cle_q;
	logic ale_q;
	logic we_n_q;
	logic re_n_q;
	logic [15:0] io_out_q;
	logic io_oe_q;

	logic access;
	logic wr_stream;
	logic rd_fetch;
	logic parity_clear;
	logic tick;
	logic start_rd;
	logic ecc_step;
	logic [1:0] last_beat;
	logic [31:0] word_next;
	logic [15:0] beat_val;
	logic [31:0] read_mux;
	nfc_pkg::nfc_kind_t push_kind;
	nfc_pkg::nfc_kind_t pop_kind;

	nfc_stream_if #(.W(nfc_pkg::ENTRY_W)) push_if ();
	nfc_stream_if #(.W(nfc_pkg::ENTRY_W)) pop_if ();

	nfc_fifo #(
		.WIDTH(nfc_pkg::ENTRY_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.push(push_if),
		.pop(pop_if)
	);

	// ==========================================================
	// Bus decode. A stalled stream write holds the access phase open.
	assign access = PSEL_IN && PENABLE_IN && !pready_q;
	assign wr_stream = access && PWRITE_IN && enable_q && (PADDR_IN == nfc_pkg::NFC_CMD ||
		PADDR_IN == nfc_pkg::NFC_ADDR || PADDR_IN == nfc_pkg::NFC_DATA);
	assign rd_fetch = access && !PWRITE_IN && enable_q && is_fetch(PADDR_IN);
	assign parity_clear = access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_CONTROL &&
		PWDATA_IN[nfc_pkg::CTL_PARITY_CLEAR];
	assign push_kind = (PADDR_IN == nfc_pkg::NFC_CMD) ? nfc_pkg::NFC_KIND_CMD :
		(PADDR_IN == nfc_pkg::NFC_ADDR) ? nfc_pkg::NFC_KIND_ADDR : nfc_pkg::NFC_KIND_DATA;
	assign push_if.valid = wr_stream;
	assign push_if.data = {push_kind, PWDATA_IN};
	assign pop_kind = nfc_pkg::nfc_kind_t'(pop_if.data[nfc_pkg::ENTRY_W-1:nfc_pkg::DATA_W]);
	assign pop_if.ready = state_q == nfc_pkg::NFC_S_IDLE && enable_q;

	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (PADDR_IN)
			nfc_pkg::NFC_CONFIG: read_mux[nfc_pkg::CFG_WIDTH] = width_q;
			nfc_pkg::NFC_CONTROL: begin
				read_mux[nfc_pkg::CTL_ENABLE] = enable_q;
				read_mux[nfc_pkg::CTL_CS_FORCE] = cs_force_q;
				read_mux[nfc_pkg::CTL_MAIN_FREEZE] = main_freeze_q;
				read_mux[nfc_pkg::CTL_SPARE_FREEZE] = spare_freeze_q;
			end
			nfc_pkg::NFC_CMD: read_mux[7:0] = cmd_q;
			nfc_pkg::NFC_ADDR: read_mux[7:0] = addr_q;
			nfc_pkg::NFC_MECCD0: read_mux = meccd0_q;
			nfc_pkg::NFC_MECCD1: read_mux = meccd1_q;
			nfc_pkg::NFC_STATUS: begin
				read_mux[nfc_pkg::STATUS_RB] = rb_s2_q;
				read_mux[nfc_pkg::STATUS_CE] = ce_n_q;
				read_mux[nfc_pkg::STATUS_BUSY] = state_q != nfc_pkg::NFC_S_IDLE;
			end
			nfc_pkg::NFC_MRES0: read_mux = main_res0_q;
			nfc_pkg::NFC_MRES1: read_mux = main_res1_q;
			nfc_pkg::NFC_SRES: read_mux = spare_res_q;
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// APB answer. Every access takes at least one wait state.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= nfc_pkg::WORD_RST;
			rd_req_q <= 1'b0;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			if (rd_done_q) begin
				rd_req_q <= 1'b0;
				pready_q <= 1'b1;
				prdata_q <= word_q;
			end else if (rd_fetch) begin
				rd_req_q <= 1'b1;
			end else if (access && !(wr_stream && !push_if.ready)) begin
				pready_q <= 1'b1;
				pslverr_q <= !is_mapped(PADDR_IN);
				prdata_q <= PWRITE_IN ? nfc_pkg::WORD_RST : read_mux;
			end
		end
	end

	// ==========================================================
	// Control and configuration. The width strap is caught after release.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			enable_q <= nfc_pkg::ENABLE_RST;
			cs_force_q <= nfc_pkg::CS_FORCE_RST;
			main_freeze_q <= nfc_pkg::MAIN_FREEZE_RST;
			spare_freeze_q <= nfc_pkg::SPARE_FREEZE_RST;
			width_q <= 1'b0;
			strap_pend_q <= 1'b1;
		end else begin
			if (strap_pend_q) begin
				width_q <= strap_s2_q;
				strap_pend_q <= 1'b0;
			end
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_CONFIG) begin
				width_q <= PWDATA_IN[nfc_pkg::CFG_WIDTH];
			end
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_CONTROL) begin
				enable_q <= PWDATA_IN[nfc_pkg::CTL_ENABLE];
				cs_force_q <= PWDATA_IN[nfc_pkg::CTL_CS_FORCE];
				main_freeze_q <= PWDATA_IN[nfc_pkg::CTL_MAIN_FREEZE];
				spare_freeze_q <= PWDATA_IN[nfc_pkg::CTL_SPARE_FREEZE];
			end
		end
	end

	// ==========================================================
	// Command, address and fetched parity words.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cmd_q <= nfc_pkg::CMD_RST;
			addr_q <= nfc_pkg::ADDR_RST;
			meccd0_q <= nfc_pkg::WORD_RST;
			meccd1_q <= nfc_pkg::WORD_RST;
		end else begin
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_CMD) begin
				cmd_q <= PWDATA_IN[7:0];
			end
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_ADDR) begin
				addr_q <= PWDATA_IN[7:0];
			end
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_MECCD0) begin
				meccd0_q <= PWDATA_IN;
			end
			if (access && PWRITE_IN && PADDR_IN == nfc_pkg::NFC_MECCD1) begin
				meccd1_q <= PWDATA_IN;
			end
			// Flash byte order lands the lanes as bits 15:0 then 31:16 on a wide bus, and bytes 7:0 to 31:24 on a narrow one.
			if (rd_done_q && PADDR_IN == nfc_pkg::NFC_MECCD0) begin
				meccd0_q <= word_q;
			end
			if (rd_done_q && PADDR_IN == nfc_pkg::NFC_MECCD1) begin
				meccd1_q <= word_q;
			end
		end
	end

	// ==========================================================
	// Pin synchronisers.
	always_ff @(posedge CLK_IN) begin
		rb_s1_q <= FLASH_RB_IN;
		rb_s2_q <= rb_s1_q;
		strap_s1_q <= WIDTH_STRAP_IN;
		strap_s2_q <= strap_s1_q;
		io_s1_q <= FLASH_IO_IN;
		io_s2_q <= io_s1_q;
	end

	// ==========================================================
	// Chip enable. Boot load overrides software so the loader owns the chip.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ce_n_q <= 1'b1;
		end else if (BOOT_LOAD_IN) begin
			ce_n_q <= 1'b0;
		end else begin
			ce_n_q <= enable_q ? cs_force_q : 1'b1;
		end
	end

	// ==========================================================
	// Flash sequencer: each beat is one strobe low phase and one high phase.
	assign tick = div_q == 8'(STROBE_CYC - 1);
	assign last_beat = (reading_q || kind_q == nfc_pkg::NFC_KIND_DATA) ?
		(width_q ? 2'h1 : 2'h3) : 2'h0;
	assign word_next = width_q ? {16'h0000, word_q[31:16]} : {8'h00, word_q[31:8]};
	assign start_rd = state_q == nfc_pkg::NFC_S_IDLE && enable_q && !pop_if.valid &&
		rd_req_q && !rd_done_q;
	assign beat_val = reading_q ? lane_of({16'h0000, io_s2_q}, width_q) : lane_of(word_q, width_q);
	assign ecc_step = state_q == nfc_pkg::NFC_S_LOW && tick &&
		(reading_q || kind_q == nfc_pkg::NFC_KIND_DATA);

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_q <= nfc_pkg::NFC_S_IDLE;
			kind_q <= nfc_pkg::NFC_KIND_CMD;
			beat_q <= 2'h0;
			reading_q <= 1'b0;
			word_q <= nfc_pkg::WORD_RST;
			div_q <= 8'h00;
			rd_done_q <= 1'b0;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			io_out_q <= 16'h0000;
			io_oe_q <= 1'b0;
		end else begin
			rd_done_q <= 1'b0;
			div_q <= (state_q == nfc_pkg::NFC_S_IDLE || tick) ? 8'h00 : div_q + 8'h01;
			unique case (state_q)
				nfc_pkg::NFC_S_IDLE: begin
					beat_q <= 2'h0;
					if (pop_if.valid && pop_if.ready) begin
						kind_q <= pop_kind;
						word_q <= pop_if.data[31:0];
						reading_q <= 1'b0;
						state_q <= nfc_pkg::NFC_S_LOW;
						cle_q <= pop_kind == nfc_pkg::NFC_KIND_CMD;
						ale_q <= pop_kind == nfc_pkg::NFC_KIND_ADDR;
						we_n_q <= 1'b0;
						io_oe_q <= 1'b1;
						io_out_q <= (pop_kind == nfc_pkg::NFC_KIND_DATA) ?
							lane_of(pop_if.data[31:0], width_q) :
							{8'h00, pop_if.data[7:0]};
					end else if (start_rd) begin
						kind_q <= nfc_pkg::NFC_KIND_DATA;
						reading_q <= 1'b1;
						word_q <= nfc_pkg::WORD_RST;
						state_q <= nfc_pkg::NFC_S_LOW;
						re_n_q <= 1'b0;
					end
				end
				nfc_pkg::NFC_S_LOW: begin
					if (tick) begin
						state_q <= nfc_pkg::NFC_S_HIGH;
						we_n_q <= 1'b1;
						re_n_q <= 1'b1;
						if (reading_q) begin
							word_q <= width_q ? {io_s2_q, word_q[31:16]} :
								{io_s2_q[7:0], word_q[31:8]};
						end
					end
				end
				nfc_pkg::NFC_S_HIGH: begin
					if (tick && beat_q == last_beat) begin
						state_q <= nfc_pkg::NFC_S_IDLE;
						cle_q <= 1'b0;
						ale_q <= 1'b0;
						io_oe_q <= 1'b0;
						rd_done_q <= reading_q;
					end else if (tick) begin
						beat_q <= beat_q + 2'h1;
						state_q <= nfc_pkg::NFC_S_LOW;
						if (reading_q) begin
							re_n_q <= 1'b0;
						end else begin
							we_n_q <= 1'b0;
							word_q <= word_next;
							io_out_q <= lane_of(word_next, width_q);
						end
					end
				end
				default: state_q <= nfc_pkg::NFC_S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Parity engine: per lane, a byte XOR, an odd-beat XOR and a byte sum.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || parity_clear) begin
			main_res0_q <= nfc_pkg::WORD_RST;
			main_res1_q <= nfc_pkg::WORD_RST;
			spare_res_q <= nfc_pkg::WORD_RST;
		end else if (ecc_step) begin
			if (!main_freeze_q) begin
				main_res0_q[15:0] <= main_res0_q[15:0] ^ beat_val;
				if (beat_q[0]) begin
					main_res0_q[31:16] <= main_res0_q[31:16] ^ beat_val;
				end
				main_res1_q[15:0] <= main_res1_q[15:0] + {8'h00, beat_val[7:0]};
				main_res1_q[31:16] <= main_res1_q[31:16] + {8'h00, beat_val[15:8]};
			end
			if (!spare_freeze_q) begin
				spare_res_q[15:0] <= spare_res_q[15:0] ^ beat_val;
			end
		end
	end

	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = pslverr_q;
	assign FLASH_IO_OUT = io_out_q;
	assign FLASH_IO_OE_OUT = io_oe_q;
	assign FLASH_CHIP_ENABLE_N_OUT = ce_n_q;
	assign FLASH_CLE_OUT = cle_q;
	assign FLASH_ALE_OUT = ale_q;
	assign FLASH_WE_N_OUT = we_n_q;
	assign FLASH_RE_N_OUT = re_n_q;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	ce_disabled_a: assert property (
		!BOOT_LOAD_IN && !enable_q |=> FLASH_CHIP_ENABLE_N_OUT)
		else $error("chip enable active while controller disabled");
	ce_follow_a: assert property (
		!BOOT_LOAD_IN && enable_q |=> FLASH_CHIP_ENABLE_N_OUT == $past(cs_force_q))
		else $error("chip enable does not follow the force bit");
	boot_ce_a: assert property (
		BOOT_LOAD_IN |=> !FLASH_CHIP_ENABLE_N_OUT)
		else $error("chip enable not driven during boot load");
	parity_clear_a: assert property (
		parity_clear |=> main_res0_q == 32'h0000_0000 && spare_res_q == 32'h0000_0000)
		else $error("parity state not cleared");
	main_freeze_a: assert property (
		main_freeze_q && !parity_clear |=> $stable(main_res0_q) && $stable(main_res1_q))
		else $error("main parity moved while frozen");
	main_track_a: assert property (
		ecc_step && !main_freeze_q && !parity_clear |=>
		main_res0_q[15:0] == ($past(main_res0_q[15:0]) ^ $past(beat_val)))
		else $error("main parity did not absorb the beat");
	spare_freeze_a: assert property (
		spare_freeze_q && !parity_clear |=> $stable(spare_res_q))
		else $error("spare parity moved while frozen");
	cmd_cycle_a: assert property (
		state_q == nfc_pkg::NFC_S_LOW && !reading_q && kind_q == nfc_pkg::NFC_KIND_CMD |->
		FLASH_CLE_OUT && !FLASH_ALE_OUT && !FLASH_WE_N_OUT && FLASH_IO_OUT[7:0] == word_q[7:0])
		else $error("command latch cycle malformed");
	narrow_lane_a: assert property (
		!width_q && FLASH_IO_OE_OUT && state_q == nfc_pkg::NFC_S_LOW |->
		FLASH_IO_OUT[15:8] == 8'h00)
		else $error("upper lane driven on a narrow bus");
	fetch_answer_a: assert property (
		rd_done_q |=> PREADY_OUT && PRDATA_OUT == $past(word_q))
		else $error("fetched word not returned");
	no_run_disabled_a: assert property (
		!enable_q && state_q == nfc_pkg::NFC_S_IDLE |=> state_q == nfc_pkg::NFC_S_IDLE)
		else $error("flash cycle started while disabled");

	cmd_seen_c: cover property (FLASH_CLE_OUT && !FLASH_WE_N_OUT);
	fetch_seen_c: cover property (rd_done_q && width_q);
	fifo_full_c: cover property (wr_stream && !push_if.ready);
	freeze_unlock_c: cover property (ecc_step && !main_freeze_q && !spare_freeze_q);
endmodule : nfc_ctrl

// *** tb/nfc_flash_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Behavioural flash: latches command and address bytes, counts data beats,
// and serves an ascending byte pattern on each read strobe.
module nfc_flash_model (
	input wire logic cle_in,
	input wire logic ale_in,
	input wire logic we_n_in,
	input wire logic re_n_in,
	input wire logic [15:0] drive_in,
	output logic [15:0] io_out,
	output logic [7:0] cmd_out,
	output logic [7:0] addr_out,
	output logic [15:0] data_out,
	output int cmd_cnt_out,
	output int data_cnt_out
);
	logic [7:0] n_q;
	logic we_arm;
	logic re_arm;
	initial begin
		n_q = 8'h00;
		we_arm = 1'b0;
		re_arm = 1'b0;
		cmd_out = 8'h00;
		addr_out = 8'h00;
		data_out = 16'h0000;
		cmd_cnt_out = 0;
		data_cnt_out = 0;
	end
	// A released bus shows the inverse, so a stale sample cannot match by luck.
	assign io_out = re_n_in ? ~{8'h00, 8'ha0 + n_q} : {8'h00, 8'ha0 + n_q};
	// Strobe edges out of an unknown level at power-up are not beats.
	always @(negedge we_n_in) we_arm = 1'b1;
	always @(negedge re_n_in) re_arm = 1'b1;
	always @(posedge re_n_in) begin
		if (re_arm) n_q = n_q + 8'h01;
		re_arm = 1'b0;
	end
	always @(posedge we_n_in) begin
		if (we_arm && cle_in === 1'b1) begin
			cmd_out = drive_in[7:0];
			cmd_cnt_out++;
		end else if (we_arm && ale_in === 1'b1) begin
			addr_out = drive_in[7:0];
		end else if (we_arm) begin
			data_cnt_out++;
			data_out = drive_in;
		end
		we_arm = 1'b0;
	end
endmodule : nfc_flash_model

// *** tb/nand_flash_ctrl_regs_ecc_bench.sv ***
`timescale 1ns/1ns
module nand_flash_ctrl_regs_ecc_bench;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, boot = 0, rdy, serr, e;
	logic ioe, ce_n, cle, ale, we_n, re_n;
	logic [31:0] pa = 0, pwd = 0, prd, r, w;
	logic [15:0] io_i, io_o, l_data;
	logic [7:0] l_cmd, l_addr;
	int err_total = 0, total_checks = 0, dcnt, ccnt, rk = 0, d0;
	// ==========================================================
	// Design and flash model.
	// A read strobe must outlast the two-flop input path, so the default strobe length is kept.
	nfc_ctrl #(.STROBE_CYC(nfc_pkg::STROBE_CYC), .FIFO_DEPTH(4)) dut (.CLK_IN(clk), .RST_IN(rst),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(serr), .BOOT_LOAD_IN(boot),
		.WIDTH_STRAP_IN(1'b0), .FLASH_RB_IN(1'b1), .FLASH_IO_IN(io_i), .FLASH_IO_OUT(io_o),
		.FLASH_IO_OE_OUT(ioe), .FLASH_CHIP_ENABLE_N_OUT(ce_n), .FLASH_CLE_OUT(cle),
		.FLASH_ALE_OUT(ale), .FLASH_WE_N_OUT(we_n), .FLASH_RE_N_OUT(re_n));
	nfc_flash_model fm (.cle_in(cle), .ale_in(ale), .we_n_in(we_n), .re_n_in(re_n),
		.drive_in(io_o), .io_out(io_i), .cmd_out(l_cmd), .addr_out(l_addr),
		.cmd_cnt_out(ccnt), .data_cnt_out(dcnt), .data_out(l_data));
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks.
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// Only whole-word transfers are issued; only the watchdog ends a wait.
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = prd;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic fetch(input logic [31:0] a);
		w = 32'ha3a2_a1a0 + {4{rk[7:0]}};
		apb(1'b0, a, 32'h0000_0000);
		chk("fetch word", r, w);
		rk += 4;
	endtask : fetch
	task automatic ce(input logic x);
		repeat (2) @(posedge clk);
		chk("chip enable", {31'h0, ce_n}, {31'h0, x});
	endtask : ce
	// ==========================================================
	// Scenarios.
	task automatic t_reset;
		apb(1'b0, nfc_pkg::NFC_CONTROL, 32'h0000_0000);
		chk("control", r & 32'h0000_0073, 32'h0000_0062);
		apb(1'b0, nfc_pkg::NFC_CMD, 32'h0000_0000);
		chk("command", r, 32'h0000_0000);
		apb(1'b0, nfc_pkg::NFC_MECCD0, 32'h0000_0000);
		chk("ecc first", r, 32'h0000_0000);
		apb(1'b0, nfc_pkg::NFC_MECCD1, 32'h0000_0000);
		chk("ecc second", r, 32'h0000_0000);
		$display("done reset");
	endtask : t_reset
	task automatic t_cs;
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0000);
		ce(1'b1);
		apb(1'b1, nfc_pkg::NFC_CMD, 32'h0000_0077);
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0001);
		ce(1'b0);
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0013);
		ce(1'b1);
		apb(1'b0, nfc_pkg::NFC_CONTROL, 32'h0000_0000);
		chk("clear bit", r & 32'h0000_0010, 32'h0000_0000);
		boot <= 1'b1;
		ce(1'b0);
		boot <= 1'b0;
		ce(1'b1);
		apb(1'b0, 32'h4e00_0040, 32'h0000_0000);
		chk("unmapped error", {31'h0, e}, 32'h0000_0001);
		$display("done chip select");
	endtask : t_cs
	task automatic t_latch;
		apb(1'b1, nfc_pkg::NFC_CMD, 32'h0000_1290);
		apb(1'b1, nfc_pkg::NFC_ADDR, 32'h0000_ff5a);
		apb(1'b0, nfc_pkg::NFC_CMD, 32'h0000_0000);
		chk("command", r, 32'h0000_0090);
		apb(1'b0, nfc_pkg::NFC_ADDR, 32'h0000_0000);
		chk("address", r, 32'h0000_005a);
		fetch(nfc_pkg::NFC_DATA);
		chk("latched command", {24'h0, l_cmd}, 32'h0000_0090);
		chk("latched address", {24'h0, l_addr}, 32'h0000_005a);
		chk("command cycles", ccnt, 1);
		fetch(nfc_pkg::NFC_MECCD0);
		fetch(nfc_pkg::NFC_MECCD1);
		d0 = dcnt;
		for (int i = 0; i < 7; i++) apb(1'b1, nfc_pkg::NFC_DATA, 32'h1111_1111 * i);
		fetch(nfc_pkg::NFC_DATA);
		chk("write beats", dcnt - d0, 28);
		chk("last data beat", {16'h0000, l_data}, 32'h0000_0066);
		$display("done latch and stream");
	endtask : t_latch
	task automatic t_parity;
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0071);
		fetch(nfc_pkg::NFC_DATA);
		apb(1'b0, nfc_pkg::NFC_MRES0, 32'h0000_0000);
		chk("main frozen", r, 32'h0000_0000);
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0051);
		fetch(nfc_pkg::NFC_DATA);
		apb(1'b0, nfc_pkg::NFC_MRES0, 32'h0000_0000);
		chk("main parity", r[15:0], {8'h00, w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24]});
		apb(1'b0, nfc_pkg::NFC_MRES1, 32'h0000_0000);
		chk("main sums", r, 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]));
		apb(1'b0, nfc_pkg::NFC_SRES, 32'h0000_0000);
		chk("spare frozen", r, 32'h0000_0000);
		apb(1'b1, nfc_pkg::NFC_CONTROL, 32'h0000_0031);
		fetch(nfc_pkg::NFC_DATA);
		apb(1'b0, nfc_pkg::NFC_SRES, 32'h0000_0000);
		chk("spare parity", r[15:0], {8'h00, w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24]});
		$display("done parity");
	endtask : t_parity
	task automatic t_wide;
		apb(1'b1, nfc_pkg::NFC_CONFIG, 32'h0000_0001);
		d0 = dcnt;
		apb(1'b1, nfc_pkg::NFC_DATA, 32'h4433_2211);
		w = {8'h00, 8'ha1 + rk[7:0], 8'h00, 8'ha0 + rk[7:0]};
		apb(1'b0, nfc_pkg::NFC_DATA, 32'h0000_0000);
		chk("wide fetch", r, w);
		chk("wide beats", dcnt - d0, 2);
		chk("wide data", {16'h0000, l_data}, 32'h0000_4433);
		rk += 2;
		$display("done wide bus");
	endtask : t_wide
	// ==========================================================
	// Sequence, watchdog and verdict.
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		#300000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cs();
		t_latch();
		t_parity();
		t_wide();
		print_verdict();
	end
endmodule : nand_flash_ctrl_regs_ecc_bench
